/* File: hdl/acs_chan_reg.sv */
`timescale 1ns/1ps
`include "acs_consts.svh"

module acs_chan_reg #(
  parameter logic [15:0] RST = `ACS_CHN_RST
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              wr_en,
  input  wire logic [15:0]       wdata,
  input  wire logic [1:0]        wstrb,
  output logic [15:0]            rdata,
  output acs_pkg::acs_chan_t     chan,
  output acs_pkg::acs_route_t    pos_route,
  output acs_pkg::acs_route_t    neg_route
);

  logic [15:0] reg_q;

  // Reserved bits never latch, so they read zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_q <= RST;
    end else if (wr_en) begin
      reg_q <= acs_pkg::acs_merge(reg_q, wdata, wstrb, `ACS_CH_WMASK);
    end
  end

  assign rdata = reg_q;

  // Same layout on every channel
  assign chan.channel_enable        = reg_q[`ACS_CH_EN_BIT];
  assign chan.setup_select          = reg_q[`ACS_CH_SSEL_LSB +: 2];
  assign chan.positive_input_select = reg_q[`ACS_CH_POS_LSB +: 5];
  assign chan.negative_input_select = reg_q[`ACS_CH_NEG_LSB +: 5];

  // Both selects share one source encoding
  assign pos_route = acs_pkg::acs_src_decode(chan.positive_input_select);
  assign neg_route = acs_pkg::acs_src_decode(chan.negative_input_select);

endmodule

/* File: hdl/acs_consts.svh */
`ifndef ACS_CONSTS_SVH
`define ACS_CONSTS_SVH

// Register indices; byte address is four times the index
`define ACS_IDX_STATUS   10'h001
`define ACS_IDX_CH0      10'h010
`define ACS_IDX_CH1      10'h011
`define ACS_IDX_CH2      10'h012
`define ACS_IDX_CH3      10'h013
`define ACS_IDX_SETUP0   10'h020

// Reset values
`define ACS_CH0_RST      16'h0001
`define ACS_CHN_RST      16'h0001
`define ACS_SETUP0_RST   16'h1320

// Writable bits; all others read back as zero
`define ACS_CH_WMASK     16'hB3FF
`define ACS_SETUP_WMASK  16'h1F30

// Channel register fields
`define ACS_CH_EN_BIT    15
`define ACS_CH_SSEL_LSB  12
`define ACS_CH_POS_LSB   5
`define ACS_CH_NEG_LSB   0

// Setup register fields
`define ACS_SU_CODE_BIT  12
`define ACS_SU_REFP_BIT  11
`define ACS_SU_REFN_BIT  10
`define ACS_SU_AINP_BIT  9
`define ACS_SU_AINN_BIT  8
`define ACS_SU_RSEL_LSB  4

// Input source codes
`define ACS_SRC_ANALOG_INPUT_0     5'h00
`define ACS_SRC_ANALOG_INPUT_4     5'h04
`define ACS_SRC_TEMP_P   5'h11
`define ACS_SRC_TEMP_N   5'h12
`define ACS_SRC_SUP_P    5'h13
`define ACS_SRC_SUP_N    5'h14
`define ACS_SRC_REF_P    5'h15
`define ACS_SRC_REF_N    5'h16

`endif

/* File: hdl/acs_pkg.sv */
`include "acs_consts.svh"

package acs_pkg;

  typedef struct packed {
    logic       channel_enable;
    logic [1:0] setup_select;
    logic [4:0] positive_input_select;
    logic [4:0] negative_input_select;
  } acs_chan_t;

  typedef struct packed {
    logic       output_coding_select;
    logic       ref_pos_buffer_enable;
    logic       ref_neg_buffer_enable;
    logic       ain_pos_buffer_enable;
    logic       ain_neg_buffer_enable;
    logic [1:0] ref_source_select;
  } acs_setup_t;

  // One-hot mux drive: 0..4 analog inputs, 5/6 temp, 7/8 supply/5, 9/10 ref
  typedef struct packed {
    logic        valid;
    logic [10:0] onehot;
  } acs_route_t;

  typedef enum logic [1:0] {
    ACS_SCAN_IDLE = 2'b01,
    ACS_SCAN_RUN  = 2'b10
  } acs_scan_t;

  // Reserved codes leave every switch open
  function automatic acs_route_t acs_src_decode(input logic [4:0] code);
    acs_route_t r;
    r = '0;
    r.valid = 1'b1;
    if (code <= `ACS_SRC_ANALOG_INPUT_4) begin
      r.onehot[code[2:0]] = 1'b1;
    end else if (code >= `ACS_SRC_TEMP_P && code <= `ACS_SRC_REF_N) begin
      r.onehot[4'(code - `ACS_SRC_TEMP_P) + 4'h5] = 1'b1;
    end else begin
      r.valid = 1'b0;
    end
    return r;
  endfunction

  // Byte-lane write merge, only writable bits change
  function automatic logic [15:0] acs_merge(input logic [15:0] old,
                                            input logic [15:0] wdata,
                                            input logic [1:0]  strb,
                                            input logic [15:0] wmask);
    logic [15:0] lanes;
    lanes = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
    return (old & ~lanes) | (wdata & lanes);
  endfunction

endpackage

/* File: hdl/acs_regs.sv */
// Chosen here: register access over APB.
`timescale 1ns/1ps
`include "acs_consts.svh"

// Operation
// - Negative select routes negative input, listed codes
// - First channel negative select resets to one
// - Channels at 0x11-0x13 reset to 0x0001
// - Further channels share first channel field layout
// - Setup zero at 0x20, resets 0x1320
// - Setup register is 16 bits wide
// - Setup bits 15:13 reserved, read zero
// - Bit 12 picks unipolar or bipolar coding
// - Bit 11 enables positive reference buffer
// - Bit 10 enables negative reference buffer
// - Positive select in bits 9:5, same codes
module acs_regs (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              conv_done,
  output acs_pkg::acs_chan_t [3:0]  chan_cfg,
  output acs_pkg::acs_route_t [3:0] chan_pos_route,
  output acs_pkg::acs_route_t [3:0] chan_neg_route,
  output acs_pkg::acs_setup_t    setup0_cfg,
  output logic                   scan_active,
  output logic [1:0]             active_chan,
  output logic [1:0]             active_setup_sel,
  output acs_pkg::acs_route_t    active_pos_route,
  output acs_pkg::acs_route_t    active_neg_route
);

  // Bus decode
  logic [9:0]        idx;
  logic              aligned;
  logic              hit_status;
  logic              hit_setup;
  logic [3:0]        hit_ch;
  logic              mapped;
  logic              setup_phase;
  logic              access_phase;
  logic              wr_ok;
  logic [31:0]       rd_mux;
  logic [31:0]       prdata_q;

  // Register storage outputs
  logic [15:0]       ch_rdata [4];
  logic [15:0]       setup_rdata;
  logic [3:0]        ch_wr;
  logic              setup_wr;
  logic [3:0]        en_mask;

  // Scan state
  acs_pkg::acs_scan_t  scan_q;
  acs_pkg::acs_scan_t  scan_d;
  logic [1:0]          cur_q;
  logic [1:0]          cur_d;
  logic                bad_route_q;
  acs_pkg::acs_route_t pos_out_q;
  acs_pkg::acs_route_t neg_out_q;
  logic [1:0]          ssel_q;
  logic [15:0]         status_word;

  // Next enabled channel after cur, wrapping; cur itself comes last
  function automatic logic [1:0] next_chan(input logic [3:0] en,
                                           input logic [1:0] cur);
    logic [1:0] pick;
    logic       found;
    logic [1:0] cand;
    pick  = cur;
    found = 1'b0;
    for (int i = 1; i <= 4; i++) begin
      cand = 2'(cur + 2'(i));
      if (!found && en[cand]) begin
        pick  = cand;
        found = 1'b1;
      end
    end
    return pick;
  endfunction

  // Printed offsets are word indices; low address bits must be zero
  assign idx     = paddr[11:2];
  assign aligned = (paddr[1:0] == 2'h0);

  // Address map
  always_comb begin
    hit_status = aligned && (idx == `ACS_IDX_STATUS);
    hit_setup  = aligned && (idx == `ACS_IDX_SETUP0);
    hit_ch[0]  = aligned && (idx == `ACS_IDX_CH0);
    hit_ch[1]  = aligned && (idx == `ACS_IDX_CH1);
    hit_ch[2]  = aligned && (idx == `ACS_IDX_CH2);
    hit_ch[3]  = aligned && (idx == `ACS_IDX_CH3);
  end

  assign mapped = hit_status | hit_setup | (|hit_ch);

  // Two-phase transfer, zero wait states
  assign setup_phase  = psel & ~penable;
  assign access_phase = psel & penable;
  assign pready       = access_phase;

  // Unmapped address or write to the read-only status word
  assign pslverr = access_phase & (~mapped | (pwrite & hit_status));

  // Writes land only at the completing edge
  assign wr_ok    = access_phase & pwrite & ~pslverr;
  assign ch_wr    = {4{wr_ok}} & hit_ch;
  assign setup_wr = wr_ok & hit_setup;

  // Channel 0 keeps its own reset value
  acs_chan_reg #(
    .RST (`ACS_CH0_RST)
  ) u_ch0 (
    .pclk      (pclk),
    .presetn   (presetn),
    .wr_en     (ch_wr[0]),
    .wdata     (pwdata[15:0]),
    .wstrb     (pstrb[1:0]),
    .rdata     (ch_rdata[0]),
    .chan      (chan_cfg[0]),
    .pos_route (chan_pos_route[0]),
    .neg_route (chan_neg_route[0])
  );

  // Channels 1 to 3 share one reset value and one layout
  for (genvar g = 1; g < 4; g++) begin : g_ch
    acs_chan_reg #(
      .RST (`ACS_CHN_RST)
    ) u_ch (
      .pclk      (pclk),
      .presetn   (presetn),
      .wr_en     (ch_wr[g]),
      .wdata     (pwdata[15:0]),
      .wstrb     (pstrb[1:0]),
      .rdata     (ch_rdata[g]),
      .chan      (chan_cfg[g]),
      .pos_route (chan_pos_route[g]),
      .neg_route (chan_neg_route[g])
    );
  end

  acs_setup_reg u_setup0 (
    .pclk    (pclk),
    .presetn (presetn),
    .wr_en   (setup_wr),
    .wdata   (pwdata[15:0]),
    .wstrb   (pstrb[1:0]),
    .rdata   (setup_rdata),
    .setup   (setup0_cfg)
  );

  // Enable bits of all channels
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      en_mask[i] = chan_cfg[i].channel_enable;
    end
  end

  // Status word: active channel, running, bad code, enable mask
  assign status_word = {8'h00, en_mask, bad_route_q,
                        (scan_q == acs_pkg::ACS_SCAN_RUN), cur_q};

  // Read mux; unmapped reads return zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_status) begin
      rd_mux = {16'h0000, status_word};
    end else if (hit_setup) begin
      rd_mux = {16'h0000, setup_rdata};
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (hit_ch[i]) begin
          rd_mux = {16'h0000, ch_rdata[i]};
        end
      end
    end
  end

  // Read data captured in the setup cycle, stable through access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup_phase && !pwrite) begin
      prdata_q <= rd_mux;
    end
  end

  assign prdata = prdata_q;

  // Scan sequencer: idle with nothing enabled, else round robin
  always_comb begin
    scan_d = scan_q;
    cur_d  = cur_q;
    unique case (scan_q)
      acs_pkg::ACS_SCAN_IDLE: begin
        if (|en_mask) begin
          scan_d = acs_pkg::ACS_SCAN_RUN;
          cur_d  = next_chan(en_mask, 2'h3);
        end
      end
      acs_pkg::ACS_SCAN_RUN: begin
        if (!(|en_mask)) begin
          scan_d = acs_pkg::ACS_SCAN_IDLE;
        end else if (conv_done || !en_mask[cur_q]) begin
          // A disabled current channel is left at once, not after a result
          cur_d = next_chan(en_mask, cur_q);
        end
      end
      default: begin
        scan_d = acs_pkg::ACS_SCAN_IDLE;
      end
    endcase
  end

  // Scan state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_q <= acs_pkg::ACS_SCAN_IDLE;
      cur_q  <= 2'h0;
    end else begin
      scan_q <= scan_d;
      cur_q  <= cur_d;
    end
  end

  // Mux drive for the active channel; open while idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_out_q <= '0;
      neg_out_q <= '0;
      ssel_q    <= 2'h0;
    end else if (scan_d == acs_pkg::ACS_SCAN_RUN) begin
      pos_out_q <= chan_pos_route[cur_d];
      neg_out_q <= chan_neg_route[cur_d];
      ssel_q    <= chan_cfg[cur_d].setup_select;
    end else begin
      pos_out_q <= '0;
      neg_out_q <= '0;
      ssel_q    <= 2'h0;
    end
  end

  // Reserved source code on the active channel, reported only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bad_route_q <= 1'b0;
    end else if (scan_d == acs_pkg::ACS_SCAN_RUN) begin
      bad_route_q <= ~chan_pos_route[cur_d].valid
                   | ~chan_neg_route[cur_d].valid;
    end else begin
      bad_route_q <= 1'b0;
    end
  end

  assign scan_active      = (scan_q == acs_pkg::ACS_SCAN_RUN);
  assign active_chan      = cur_q;
  assign active_setup_sel = ssel_q;
  assign active_pos_route = pos_out_q;
  assign active_neg_route = neg_out_q;

endmodule

/* File: hdl/acs_setup_reg.sv */
`timescale 1ns/1ps
`include "acs_consts.svh"

module acs_setup_reg (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              wr_en,
  input  wire logic [15:0]       wdata,
  input  wire logic [1:0]        wstrb,
  output logic [15:0]            rdata,
  output acs_pkg::acs_setup_t    setup
);

  logic [15:0] reg_q;

  // Bits 15:13 and read-only bits are masked off on write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_q <= `ACS_SETUP0_RST;
    end else if (wr_en) begin
      reg_q <= acs_pkg::acs_merge(reg_q, wdata, wstrb, `ACS_SETUP_WMASK);
    end
  end

  assign rdata = reg_q;

  assign setup.output_coding_select  = reg_q[`ACS_SU_CODE_BIT];
  assign setup.ref_pos_buffer_enable = reg_q[`ACS_SU_REFP_BIT];
  assign setup.ref_neg_buffer_enable = reg_q[`ACS_SU_REFN_BIT];
  assign setup.ain_pos_buffer_enable = reg_q[`ACS_SU_AINP_BIT];
  assign setup.ain_neg_buffer_enable = reg_q[`ACS_SU_AINN_BIT];
  assign setup.ref_source_select     = reg_q[`ACS_SU_RSEL_LSB +: 2];

endmodule

/* File: testbench/acs_regs_assertions.sv */
`timescale 1ns/1ps
module acs_regs_assertions (
  input wire logic                     pclk,
  input wire logic                     presetn,
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic [11:0]              paddr,
  input wire logic [31:0]              pwdata,
  input wire logic [3:0]               pstrb,
  input wire logic [31:0]              prdata,
  input wire logic                     pready,
  input wire logic                     pslverr,
  input wire acs_pkg::acs_chan_t [3:0]  chan_cfg,
  input wire acs_pkg::acs_route_t [3:0] chan_pos_route,
  input wire acs_pkg::acs_route_t [3:0] chan_neg_route,
  input wire acs_pkg::acs_setup_t      setup0_cfg
);
  default clocking dcb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  // Access phase qualifier, shared by the bus checks
  assign acc = psel && penable;
  a_ready_access: assert property (pready == acc) else $error("pready not zero wait");
  a_neg_ain: assert property (chan_cfg[0].negative_input_select <= 5'h04 |->
    chan_neg_route[0] == {1'b1, 11'h001 << chan_cfg[0].negative_input_select})
    else $error("neg route wrong for analog input");
  a_neg_special: assert property (chan_cfg[0].negative_input_select inside {[5'h11:5'h16]} |->
    chan_neg_route[0] == {1'b1, 11'h001 << (chan_cfg[0].negative_input_select - 5'h0C)})
    else $error("neg route wrong for internal source");
  a_pos_route: assert property (chan_cfg[2].positive_input_select <= 5'h04 |->
    chan_pos_route[2] == {1'b1, 11'h001 << chan_cfg[2].positive_input_select})
    else $error("pos route wrong");
  a_rsvd_open: assert property (!(chan_cfg[1].negative_input_select inside {[0:4], [17:22]}) |->
    chan_neg_route[1] == 12'h000) else $error("reserved code routed");
  a_reset_vals: assert property (!$past(presetn) |-> chan_cfg[0] == 13'h0001 &&
    chan_cfg[3] == 13'h0001 && setup0_cfg == 7'h4E) else $error("reset values wrong");
  a_setup_rsvd: assert property (acc && !pwrite && paddr == 12'h080 |->
    prdata[31:13] == 19'h00000 && !pslverr) else $error("setup reserved bits not zero");
  a_coding_wr: assert property (acc && pwrite && paddr == 12'h080 && pstrb[1] |=>
    setup0_cfg.output_coding_select == $past(pwdata[12])) else $error("coding not written");
  a_refbuf_wr: assert property (acc && pwrite && paddr == 12'h080 && pstrb[1] |=>
    {setup0_cfg.ref_pos_buffer_enable, setup0_cfg.ref_neg_buffer_enable} == $past(pwdata[11:10]))
    else $error("ref buffer enables not written");
  a_chan_decode: assert property (acc && pwrite && paddr == 12'h04C && pstrb[1:0] == 2'h3 |=>
    chan_cfg[3] == {$past(pwdata[15]), $past(pwdata[13:12]), $past(pwdata[9:0])})
    else $error("last channel write wrong");
  a_unmapped_err: assert property (acc && paddr == 12'h0F0 |-> pslverr) else $error("no error");
endmodule

bind acs_regs acs_regs_assertions acs_regs_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .chan_cfg(chan_cfg),
  .chan_pos_route(chan_pos_route), .chan_neg_route(chan_neg_route), .setup0_cfg(setup0_cfg));

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic                     pclk = 1'b0;
  logic                     presetn = 1'b0;
  logic                     psel = 1'b0;
  logic                     penable = 1'b0;
  logic                     pwrite = 1'b0;
  logic                     conv_done = 1'b0;
  logic [11:0]              paddr = 12'h000;
  logic [31:0]              pwdata = 32'h0;
  logic [3:0]               pstrb = 4'h0;
  logic [31:0]              prdata;
  logic [31:0]              rd;
  logic                     pready;
  logic                     pslverr;
  logic                     er;
  logic                     scan_active;
  logic [1:0]               active_chan;
  logic [1:0]               active_setup_sel;
  acs_pkg::acs_chan_t [3:0]  chan_cfg;
  acs_pkg::acs_route_t [3:0] chan_pos_route;
  acs_pkg::acs_route_t [3:0] chan_neg_route;
  acs_pkg::acs_route_t      active_pos_route;
  acs_pkg::acs_route_t      active_neg_route;
  acs_pkg::acs_setup_t      setup0_cfg;
  int                       miscompares = 0;
  int                       cmp_count = 0;
  int                       seed = 83134;
  logic [15:0]              mdl [5];
  logic [11:0]              adr [5] = '{12'h040, 12'h044, 12'h048, 12'h04C, 12'h080};

  always #25 pclk = ~pclk;

  // Scan input starts low; the bench pulses it later to step the scan and checks the scan outputs
  acs_regs acs_regs_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .conv_done(conv_done), .chan_cfg(chan_cfg),
    .chan_pos_route(chan_pos_route), .chan_neg_route(chan_neg_route),
    .setup0_cfg(setup0_cfg), .scan_active(scan_active), .active_chan(active_chan),
    .active_setup_sel(active_setup_sel), .active_pos_route(active_pos_route),
    .active_neg_route(active_neg_route));

  task automatic test_done;
    $display("Compares %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      miscompares++;
      test_done();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Write and mirror it in the model, only enabled lanes and writable bits
  task automatic wr(input int i, input logic [15:0] d, input logic [1:0] s);
    logic [15:0] ln;
    ln = {{8{s[1]}}, {8{s[0]}}} & (i == 4 ? 16'h1F30 : 16'hB3FF);
    // Host keeps the reserved top bits of the setup word at zero
    if (i == 4) d = d & 16'h1FFF;
    apb(1'b1, adr[i], {16'hA5A5, d}, {2'b11, s});
    mdl[i] = (mdl[i] & ~ln) | (d & ln);
  endtask

  task automatic rdchk(input int i);
    logic [15:0] v;
    v = mdl[i];
    apb(1'b0, adr[i], 32'h0, 4'h0);
    chk("read", rd, {16'h0000, v});
    chk("err", 32'(er), 32'h0);
    if (i < 4) chk("chan", 32'(chan_cfg[i]), 32'({v[15], v[13:12], v[9:0]}));
    else chk("setup", 32'(setup0_cfg), 32'({v[12:8], v[5:4]}));
  endtask

  function automatic logic [11:0] rte(input int c);
    if (c <= 4) return {1'b1, 11'h001 << c};
    if (c >= 17 && c <= 22) return {1'b1, 11'h001 << (c - 12)};
    return 12'h000;
  endfunction

  // Scan outputs, looked at on the falling edge after the next rising edge, once registered values settle
  task automatic scn(input logic a, input logic [1:0] c, input logic [1:0] s, input int p,
                     input int n);
    @(posedge pclk);
    @(negedge pclk);
    chk("scan active", 32'(scan_active), 32'(a));
    chk("active chan", 32'(active_chan), 32'(c));
    chk("active setup", 32'(active_setup_sel), 32'(s));
    chk("active pos", 32'(active_pos_route), a ? 32'(rte(p)) : 32'h0);
    chk("active neg", 32'(active_neg_route), a ? 32'(rte(n)) : 32'h0);
  endtask

  initial begin
    int k;
    for (int i = 0; i < 5; i++) mdl[i] = (i == 4) ? 16'h1320 : 16'h0001;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values of every channel and the setup register
    for (int i = 0; i < 5; i++) rdchk(i);
    // Every five-bit source code on both selects of all channels
    for (int c = 0; c < 32; c++) begin
      for (int i = 0; i < 4; i++) wr(i, 16'(c * 33), 2'b11);
      @(posedge pclk);
      for (int i = 0; i < 4; i++) begin
        chk("neg", 32'(chan_neg_route[i]), 32'(rte(c)));
        chk("pos", 32'(chan_pos_route[i]), 32'(rte(c)));
      end
    end
    // Setup all ones below bit 13 then all zeros, reserved bits must stay zero
    wr(4, 16'hFFFF, 2'b11);
    rdchk(4);
    wr(4, 16'h0000, 2'b11);
    rdchk(4);
    // Random data and lane strobes over all channel and setup registers
    repeat (60) begin
      k = $unsigned($random(seed)) % 5;
      wr(k, 16'($random(seed)), 2'($random(seed)));
      rdchk(k);
    end
    // Scan over channels 1 and 2, one step per conversion result
    for (int i = 0; i < 4; i++) wr(i, 16'h0001, 2'b11);
    wr(1, 16'h9043, 2'b11);
    wr(2, 16'hA091, 2'b11);
    scn(1'b1, 2'h1, 2'h1, 2, 3);
    apb(1'b0, 12'h004, 32'h0, 4'h0);
    chk("status", rd, 32'h0000_0065);
    apb(1'b1, 12'h004, 32'h0, 4'hF);
    chk("status write err", 32'(er), 32'h1);
    for (int j = 0; j < 2; j++) begin
      @(posedge pclk);
      conv_done <= 1'b1;
      @(posedge pclk);
      conv_done <= 1'b0;
      if (j == 0) scn(1'b1, 2'h2, 2'h2, 4, 17);
      else scn(1'b1, 2'h1, 2'h1, 2, 3);
    end
    // Disabling the current channel moves on without a result
    wr(1, 16'h0001, 2'b11);
    scn(1'b1, 2'h2, 2'h2, 4, 17);
    wr(2, 16'h0001, 2'b11);
    scn(1'b0, 2'h2, 2'h0, 0, 0);
    // Unmapped and unaligned places refuse and leave registers alone
    apb(1'b0, 12'h0F0, 32'h0, 4'h0);
    chk("unmapped err", 32'(er), 32'h1);
    chk("unmapped data", rd, 32'h0);
    apb(1'b1, 12'h042, 32'hFFFF, 4'hF);
    chk("unaligned err", 32'(er), 32'h1);
    for (int i = 0; i < 5; i++) rdchk(i);
    test_done();
  end

  // Hang guard
  initial begin
    repeat (30000) @(posedge pclk);
    miscompares++;
    test_done();
  end
endmodule
